// [design/pllc_defs.svh]
/*
  register offsets, bit positions, reset values and widths of the loop
  control block. assumes it is included by bare name, once per unit.
*/
`ifndef PLLC_DEFS_SVH
`define PLLC_DEFS_SVH

// byte addresses on the apb bus, one aligned word each
`define PLLC_OFF_CTRL 12'h000
`define PLLC_OFF_BWC 12'h004
`define PLLC_OFF_MULH 12'h008
`define PLLC_OFF_MULL 12'h00C
`define PLLC_OFF_VRS 12'h010
`define PLLC_OFF_RDS 12'h014
`define PLLC_ADDR_W 12

// loop control register bit positions
`define PLLC_CTRL_IE 7
`define PLLC_CTRL_FLAG 6
`define PLLC_CTRL_ON 5
`define PLLC_CTRL_BASE_SEL 4
`define PLLC_CTRL_PRE_HI 3
`define PLLC_CTRL_PRE_LO 2
`define PLLC_CTRL_VPR_HI 1
`define PLLC_CTRL_VPR_LO 0

// bandwidth control register bit positions
`define PLLC_BWC_AUTO 7
`define PLLC_BWC_LOCK 6
`define PLLC_BWC_TRACK 5

// data field positions within the write word
`define PLLC_NIB_HI 3
`define PLLC_NIB_LO 0
`define PLLC_BYTE_HI 7

// reset values
`define PLLC_RST_MULH 4'h0
`define PLLC_RST_MULL 8'h40
`define PLLC_RST_VRS 8'h40
`define PLLC_RST_RDS 4'h1
`define PLLC_RST_EXP 2'h0
`define PLLC_RST_PRE 2'h0

// substitutes for programmed zeros
`define PLLC_MUL_ZERO 12'h000
`define PLLC_MUL_ONE 12'h001
`define PLLC_RDS_ZERO 4'h0
`define PLLC_RDS_ONE 4'h1
`define PLLC_VRS_ZERO 8'h00

// range multiplier decode
`define PLLC_EXP_X1 2'h0
`define PLLC_EXP_X2 2'h1
`define PLLC_EXP_X4 2'h2
`define PLLC_EXP_X8 2'h3
`define PLLC_RANGE_X1 4'h1
`define PLLC_RANGE_X2 4'h2
`define PLLC_RANGE_X4 4'h4
`define PLLC_RANGE_X8 4'h8

`define PLLC_ZERO32 32'h0000_0000

`endif

// [design/pllc_pkg.sv]
/*
  types of the loop control block: the configuration bundle handed to the
  analog loop. assumes pllc_defs.svh is compiled alongside.
*/
package pllc_pkg;

  typedef struct packed {
    logic loop_enable;
    logic base_clock_select;
    logic auto_mode;
    logic tracking_mode;
    logic [1:0] prescaler;
    logic [1:0] vco_exponent;
    logic [3:0] range_multiplier;
    logic [7:0] vco_center_multiplier;
    logic [11:0] feedback_multiplier;
    logic [3:0] reference_divider;
  } pllc_cfg_t;

  typedef enum logic [1:0] {
    PLLC_BUS_IDLE,
    PLLC_BUS_ACCESS
  } pllc_bus_state_t;

endpackage : pllc_pkg

// [design/pllc_top.sv]
/*
  digital control side of a clock generator loop: the apb register file,
  write protection of the programming registers, bandwidth mode, lock
  change flag and interrupt request, and the two-flop synchroniser that
  feeds them. cfg_o carries the decoded settings to the analog loop.
  assumes a single 40 mhz bus clock and a synchronous active low reset;
  lock, tracking and stop come from outside this clock domain, and the
  analog loop treats cfg_o as quasi-static after each register write.
*/
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pllc_defs.svh"

module pllc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : pllc_sync

// Function
// R1 - two-bit exponent field decodes to range multiplier 1, 2, 4 or 8
// R2 - exponent field write-protected while loop enabled; reset clears it
// R3 - software must not program exponent 3
// R4 - bandwidth mode bit read/write, 1 automatic, 0 manual, reset manual
// R5 - software clears tracking select before enabling loop in manual mode
// R6 - lock bit read-only in automatic mode, reads zero in manual mode
// R7 - software always writes zero to lock bit; reset clears it
// R8 - tracking bit reports loop mode in automatic, forces it in manual
// R9 - manual tracking value kept during automatic mode; reset clears it
// R10 - feedback multiplier twelve bits; upper nibble of high register reads zero
// R11 - feedback multiplier zero acts as one
// R12 - feedback multiplier resets to 0x040
// R13 - multiplier, range and divider registers write-protected while loop enabled
// R14 - eight-bit centre multiplier, reset value 0x40
// R15 - centre multiplier zero disables loop and clears, blocks base clock select
// R16 - four-bit reference divider, zero acts as one, reset one
// R17 - upper nibble of reference divider register reads zero
// R18 - automatic mode lock change sets flag; irq only with enable
// R19 - manual mode blocks irq and flag reads zero
// R20 - software reads lock bit after irq to learn direction
// R21 - base clock select allowed while unlocked; software checks lock first
// R22 - wait mode leaves all settings and operation unchanged
// R23 - software may clear select then enable before wait to save power
// R24 - loop enable set at reset, cannot clear while base clock selected
// R25 - any read of control register clears lock change flag; a lock change in the same cycle keeps the flag set instead
// R26 - stop mode entry clears base clock select
module pllc_top
  import pllc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`PLLC_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic lock_detect_i,
  input wire logic loop_tracking_i,
  input wire logic stop_mode_i,
  input wire logic wait_mode_i,
  output pllc_cfg_t cfg_o,
  output logic irq_o
);

  // bus handshake state
  pllc_bus_state_t bus_state;
  pllc_bus_state_t next_bus_state;

  // synchronised analog and system inputs
  logic lock_sync;
  logic track_sync;
  logic stop_sync;
  logic stop_prev;

  // register storage
  logic irq_enable;
  logic lock_flag;
  logic loop_enable_bit;
  logic base_clock_select_bit;
  logic [1:0] prescaler;
  logic [1:0] vco_exponent;
  logic auto_mode;
  logic tracking_manual;
  logic lock_prev;
  logic [3:0] feedback_multiplier_upper;
  logic [7:0] feedback_multiplier_lower;
  logic [7:0] vco_center_multiplier;
  logic [3:0] reference_divider_field;

  // one synchroniser per input keeps each crossing independent
  pllc_sync #(
    .WIDTH(1)
  ) u_sync_lock (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i(lock_detect_i),
    .sync_o(lock_sync)
  );

  pllc_sync #(
    .WIDTH(1)
  ) u_sync_track (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i(loop_tracking_i),
    .sync_o(track_sync)
  );

  pllc_sync #(
    .WIDTH(1)
  ) u_sync_stop (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i(stop_mode_i),
    .sync_o(stop_sync)
  );

  // apb decode: setup latches read data, access phase always one cycle
  wire setup_phase = psel_i && !penable_i;
  wire access_phase = psel_i && penable_i;
  wire sel_ctrl = (paddr_i == `PLLC_OFF_CTRL);
  wire sel_bwc = (paddr_i == `PLLC_OFF_BWC);
  wire sel_mulh = (paddr_i == `PLLC_OFF_MULH);
  wire sel_mull = (paddr_i == `PLLC_OFF_MULL);
  wire sel_vrs = (paddr_i == `PLLC_OFF_VRS);
  wire sel_rds = (paddr_i == `PLLC_OFF_RDS);
  wire sel_any = sel_ctrl | sel_bwc | sel_mulh | sel_mull | sel_vrs | sel_rds;
  wire wr_en = access_phase && pwrite_i;
  wire rd_done = access_phase && !pwrite_i;

  wire wr_ctrl = wr_en && sel_ctrl;
  wire wr_bwc = wr_en && sel_bwc;
  wire wr_mulh = wr_en && sel_mulh;
  wire wr_mull = wr_en && sel_mull;
  wire wr_vrs = wr_en && sel_vrs;
  wire wr_rds = wr_en && sel_rds;

  // programming registers are frozen while the loop runs
  wire prog_open = !loop_enable_bit; // R13

  // a zero centre multiplier keeps the loop off and the vco unselected
  wire vrs_zero = (vco_center_multiplier == `PLLC_VRS_ZERO); // R15

  // status views that depend on the bandwidth mode
  wire lock_view = auto_mode & lock_sync; // R6
  wire track_view = auto_mode ? track_sync : tracking_manual; // R8
  wire flag_view = auto_mode & lock_flag; // R19
  wire ie_view = auto_mode & irq_enable; // R19

  // lock change in automatic mode; the flag set wins over a clearing read
  wire lock_change = auto_mode && (lock_view != lock_prev); // R18
  wire flag_clear = rd_done && sel_ctrl; // R25
  wire stop_entry = stop_sync && !stop_prev; // R26

  // write-side field requests
  wire wr_ie = pwdata_i[`PLLC_CTRL_IE];
  wire wr_on = pwdata_i[`PLLC_CTRL_ON];
  wire wr_base_sel = pwdata_i[`PLLC_CTRL_BASE_SEL];
  wire [1:0] wr_pre = pwdata_i[`PLLC_CTRL_PRE_HI:`PLLC_CTRL_PRE_LO];
  wire [1:0] wr_vpr = pwdata_i[`PLLC_CTRL_VPR_HI:`PLLC_CTRL_VPR_LO];
  wire wr_auto = pwdata_i[`PLLC_BWC_AUTO];
  wire wr_track = pwdata_i[`PLLC_BWC_TRACK];
  wire [3:0] wr_nibble = pwdata_i[`PLLC_NIB_HI:`PLLC_NIB_LO];
  wire [7:0] wr_byte = pwdata_i[`PLLC_BYTE_HI:`PLLC_NIB_LO];

  // enable cannot drop while the vco drives the base clock
  wire next_on_w = base_clock_select_bit ? 1'b1 : wr_on; // R24
  // select may only be set when the loop is already on; lock is not checked
  wire base_sel_allowed = loop_enable_bit && !vrs_zero; // R21

  // register read mux
  wire [7:0] ctrl_rd = {ie_view, flag_view, loop_enable_bit, base_clock_select_bit,
                        prescaler, vco_exponent};
  wire [7:0] bwc_rd = {auto_mode, lock_view, track_view, 5'h00};
  wire [7:0] mulh_rd = {4'h0, feedback_multiplier_upper}; // R10
  wire [7:0] rds_rd = {4'h0, reference_divider_field}; // R17
  wire [7:0] rd_byte = sel_ctrl ? ctrl_rd :
                       sel_bwc ? bwc_rd :
                       sel_mulh ? mulh_rd :
                       sel_mull ? feedback_multiplier_lower :
                       sel_vrs ? vco_center_multiplier :
                       sel_rds ? rds_rd : 8'h00;

  // decoded configuration towards the analog loop
  wire [11:0] mul_raw = {feedback_multiplier_upper, feedback_multiplier_lower};
  wire [11:0] mul_eff = (mul_raw == `PLLC_MUL_ZERO) ? `PLLC_MUL_ONE : mul_raw; // R11
  wire [3:0] rds_eff = (reference_divider_field == `PLLC_RDS_ZERO) ?
                       `PLLC_RDS_ONE : reference_divider_field; // R16
  logic [3:0] range_mult;

  always_comb begin
    case (vco_exponent) // R1
      `PLLC_EXP_X1: range_mult = `PLLC_RANGE_X1;
      `PLLC_EXP_X2: range_mult = `PLLC_RANGE_X2;
      `PLLC_EXP_X4: range_mult = `PLLC_RANGE_X4;
      `PLLC_EXP_X8: range_mult = `PLLC_RANGE_X8;
      default: range_mult = `PLLC_RANGE_X1;
    endcase
  end

  // bus state machine: setup, then a single access cycle
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      PLLC_BUS_IDLE: begin
        if (setup_phase) begin
          next_bus_state = PLLC_BUS_ACCESS;
        end
      end
      PLLC_BUS_ACCESS: begin
        if (setup_phase) begin
          next_bus_state = PLLC_BUS_ACCESS;
        end else begin
          next_bus_state = PLLC_BUS_IDLE;
        end
      end
      default: next_bus_state = PLLC_BUS_IDLE;
    endcase
  end

  assign pready_o = (bus_state == PLLC_BUS_ACCESS);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      bus_state <= PLLC_BUS_IDLE;
      prdata_o <= `PLLC_ZERO32;
      pslverr_o <= 1'b0;
    end else begin
      bus_state <= next_bus_state;
      if (setup_phase) begin
        prdata_o <= {24'h00_0000, rd_byte};
        pslverr_o <= !sel_any;
      end
    end
  end

  // input edge history
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      stop_prev <= 1'b0;
      lock_prev <= 1'b0;
    end else begin
      stop_prev <= stop_sync;
      lock_prev <= lock_view;
    end
  end

  // loop control register; wait mode has no input here on purpose
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_enable <= 1'b0;
      loop_enable_bit <= 1'b1; // R24
      base_clock_select_bit <= 1'b0;
      prescaler <= `PLLC_RST_PRE;
      vco_exponent <= `PLLC_RST_EXP; // R2
    end else begin
      if (!auto_mode) begin
        irq_enable <= 1'b0; // R19
      end else if (wr_ctrl) begin
        irq_enable <= wr_ie;
      end
      if (wr_ctrl) begin
        loop_enable_bit <= next_on_w; // R24
      end
      if (vrs_zero || stop_entry) begin
        base_clock_select_bit <= 1'b0; // R15 R26
      end else if (wr_ctrl) begin
        base_clock_select_bit <= wr_base_sel && base_sel_allowed; // R21
      end
      if (wr_ctrl && prog_open) begin
        prescaler <= wr_pre;
        vco_exponent <= wr_vpr; // R2
      end
    end
  end

  // lock change flag: set has priority over the read clear
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      lock_flag <= 1'b0; // R25
    end else if (!auto_mode) begin
      lock_flag <= 1'b0; // R19
    end else if (lock_change) begin
      lock_flag <= 1'b1; // R18
    end else if (flag_clear) begin
      lock_flag <= 1'b0; // R25
    end
  end

  // bandwidth control register; lock bit writes are discarded
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      auto_mode <= 1'b0; // R4
      tracking_manual <= 1'b0; // R9
    end else if (wr_bwc) begin
      auto_mode <= wr_auto; // R4
      if (!auto_mode) begin
        tracking_manual <= wr_track; // R8 R9
      end
    end
  end

  // programming registers, frozen while the loop is enabled
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      feedback_multiplier_upper <= `PLLC_RST_MULH; // R12
      feedback_multiplier_lower <= `PLLC_RST_MULL; // R12
      vco_center_multiplier <= `PLLC_RST_VRS; // R14
      reference_divider_field <= `PLLC_RST_RDS; // R16
    end else if (prog_open) begin
      if (wr_mulh) begin
        feedback_multiplier_upper <= wr_nibble; // R13
      end
      if (wr_mull) begin
        feedback_multiplier_lower <= wr_byte; // R13
      end
      if (wr_vrs) begin
        vco_center_multiplier <= wr_byte; // R13
      end
      if (wr_rds) begin
        reference_divider_field <= wr_nibble; // R13
      end
    end
  end

  // next values handed to the loop and the cpu
  pllc_cfg_t next_cfg;
  logic next_irq;

  assign next_cfg.loop_enable = loop_enable_bit && !vrs_zero; // R15
  assign next_cfg.base_clock_select = base_clock_select_bit;
  assign next_cfg.auto_mode = auto_mode;
  assign next_cfg.tracking_mode = track_view; // R8
  assign next_cfg.prescaler = prescaler;
  assign next_cfg.vco_exponent = vco_exponent;
  assign next_cfg.range_multiplier = range_mult; // R1
  assign next_cfg.vco_center_multiplier = vco_center_multiplier;
  assign next_cfg.feedback_multiplier = mul_eff; // R11
  assign next_cfg.reference_divider = rds_eff; // R16
  assign next_irq = flag_view && ie_view; // R18 R19

  // outputs to the loop and the cpu, all registered
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cfg_o <= '0;
      irq_o <= 1'b0;
    end else begin
      cfg_o <= next_cfg;
      irq_o <= next_irq;
    end
  end

  // wait mode is deliberately not used: the block runs on unchanged
  wire unused_wait = wait_mode_i; // R22

endmodule : pllc_top

// [verif/pllc_assertions.sv]
/*
  concurrent checks on the ports of pllc_top.
  assumes one clock and a synchronous active low reset.
*/
`timescale 1ns/1ps
`include "pllc_defs.svh"
module pllc_assertions
  import pllc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`PLLC_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic lock_detect_i,
  input wire logic loop_tracking_i,
  input wire logic stop_mode_i,
  input wire logic wait_mode_i,
  input wire pllc_cfg_t cfg_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire rd_acc = psel_i && penable_i && pready_o && !pwrite_i;
  chk_range_decode: assert property (
    $past(rstn_i) |-> cfg_o.range_multiplier == (4'h1 << cfg_o.vco_exponent))
    else $error("range multiplier does not match exponent");
  chk_zero_as_one: assert property (
    $past(rstn_i) |-> cfg_o.feedback_multiplier != 12'h000 && cfg_o.reference_divider != 4'h0)
    else $error("zero divider handed to the loop");
  chk_manual_no_irq: assert property (
    !cfg_o.auto_mode && !$past(cfg_o.auto_mode) |-> !irq_o)
    else $error("interrupt raised in manual mode");
  chk_unmapped_err: assert property (
    psel_i && !penable_i && paddr_i > `PLLC_OFF_RDS |=> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_nibble_zero: assert property (
    rd_acc && (paddr_i == `PLLC_OFF_MULH || paddr_i == `PLLC_OFF_RDS) |-> prdata_o[7:4] == 4'h0)
    else $error("unimplemented bits read nonzero");
  chk_manual_lock: assert property (
    rd_acc && paddr_i == `PLLC_OFF_BWC && !cfg_o.auto_mode |-> !prdata_o[`PLLC_BWC_LOCK])
    else $error("lock bit set in manual mode");
  chk_base_sel_on: assert property (
    cfg_o.base_clock_select |-> cfg_o.loop_enable)
    else $error("base clock selected with loop off");
  chk_frozen_on: assert property (
    cfg_o.loop_enable && $past(cfg_o.loop_enable) |-> $stable(cfg_o.feedback_multiplier)
      && $stable(cfg_o.vco_center_multiplier) && $stable(cfg_o.reference_divider)
      && $stable(cfg_o.vco_exponent))
    else $error("programming changed while loop on");
  // covers show the bench reached the interrupt, select and refusal paths
  cov_irq: cover property ($rose(irq_o));
  cov_base_sel: cover property ($rose(cfg_o.base_clock_select));
  cov_err: cover property (pslverr_o);
endmodule : pllc_assertions

bind pllc_top pllc_assertions u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .lock_detect_i(lock_detect_i), .loop_tracking_i(loop_tracking_i),
  .stop_mode_i(stop_mode_i), .wait_mode_i(wait_mode_i), .cfg_o(cfg_o), .irq_o(irq_o));

// [verif/pllc_top_tb.sv]
/*
  register level bench for pllc_top over apb.
  assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "pllc_defs.svh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module pllc_top_tb
  import pllc_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic lock = 1'b0;
  logic trk = 1'b0;
  logic stop = 1'b0;
  logic wt = 1'b0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic rdy;
  logic err;
  logic e;
  logic irq;
  pllc_cfg_t cfg;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  pllc_top DUT (.clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(addr), .pwdata_i(wdata), .prdata_o(rdata), .pready_o(rdy), .pslverr_o(err),
    .lock_detect_i(lock), .loop_tracking_i(trk), .stop_mode_i(stop), .wait_mode_i(wt),
    .cfg_o(cfg), .irq_o(irq));
  always #12.5 clk = ~clk;
  task automatic complete_run();
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // whole run is under a hundred transfers; the ceiling only catches a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= {24'h00_0000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // pready ends this wait; the bench timeout catches a hang
    while (rdy !== 1'b1) begin
      @(posedge clk);
    end
    q = rdata;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    // idle edge so the next call never reassigns psel in this time step
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    `CHK($sformatf("reg %h", a), {24'h00_0000, x}, q);
  endtask : rc
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rc(`PLLC_OFF_CTRL, 8'h20);
    rc(`PLLC_OFF_BWC, 8'h00);
    rc(`PLLC_OFF_MULH, 8'h00);
    rc(`PLLC_OFF_MULL, 8'h40);
    rc(`PLLC_OFF_VRS, 8'h40);
    rc(`PLLC_OFF_RDS, 8'h01);
    `CHK("feedback", 12'h040, cfg.feedback_multiplier);
    // loop still on from reset, so none of these may land
    wr(`PLLC_OFF_MULH, 8'h0F);
    wr(`PLLC_OFF_MULL, 8'h12);
    wr(`PLLC_OFF_VRS, 8'h34);
    wr(`PLLC_OFF_RDS, 8'h0F);
    wr(`PLLC_OFF_CTRL, 8'h23);
    rc(`PLLC_OFF_MULH, 8'h00);
    rc(`PLLC_OFF_MULL, 8'h40);
    rc(`PLLC_OFF_VRS, 8'h40);
    rc(`PLLC_OFF_RDS, 8'h01);
    rc(`PLLC_OFF_CTRL, 8'h20);
    apb(1'b0, 12'h100, 8'h00);
    `CHK("slave error", 1'b1, e);
    wr(`PLLC_OFF_CTRL, 8'h00);
    wr(`PLLC_OFF_MULH, 8'hFF);
    rc(`PLLC_OFF_MULH, 8'h0F);
    wr(`PLLC_OFF_MULH, 8'h00);
    wr(`PLLC_OFF_MULL, 8'h00);
    wr(`PLLC_OFF_RDS, 8'hF0);
    rc(`PLLC_OFF_RDS, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("feedback", 12'h001, cfg.feedback_multiplier);
    `CHK("divider", 4'h1, cfg.reference_divider);
    // exponent 3 is forbidden to software, so only 0 to 2 are driven
    for (int i = 0; i < 3; i++) begin
      wr(`PLLC_OFF_CTRL, {6'h00, i[1:0]});
      repeat (2) @(posedge clk);
      `CHK("range", 4'h1 << i, cfg.range_multiplier);
    end
    wr(`PLLC_OFF_CTRL, 8'h00);
    wr(`PLLC_OFF_VRS, 8'h00);
    wr(`PLLC_OFF_CTRL, 8'h20);
    wr(`PLLC_OFF_CTRL, 8'h30);
    rc(`PLLC_OFF_CTRL, 8'h20);
    `CHK("loop enable", 1'b0, cfg.loop_enable);
    wr(`PLLC_OFF_CTRL, 8'h00);
    wr(`PLLC_OFF_VRS, 8'h40);
    wr(`PLLC_OFF_CTRL, 8'h10);
    rc(`PLLC_OFF_CTRL, 8'h00);
    wr(`PLLC_OFF_BWC, 8'h00);
    wr(`PLLC_OFF_CTRL, 8'h20);
    wr(`PLLC_OFF_CTRL, 8'h30);
    rc(`PLLC_OFF_CTRL, 8'h30);
    `CHK("select", 1'b1, cfg.base_clock_select);
    wr(`PLLC_OFF_CTRL, 8'h10);
    rc(`PLLC_OFF_CTRL, 8'h30);
    wt <= 1'b1;
    repeat (5) @(posedge clk);
    rc(`PLLC_OFF_CTRL, 8'h30);
    stop <= 1'b1;
    repeat (6) @(posedge clk);
    rc(`PLLC_OFF_CTRL, 8'h20);
    stop <= 1'b0;
    wt <= 1'b0;
    wr(`PLLC_OFF_BWC, 8'h20);
    rc(`PLLC_OFF_BWC, 8'h20);
    wr(`PLLC_OFF_BWC, 8'hA0);
    rc(`PLLC_OFF_BWC, 8'h80);
    wr(`PLLC_OFF_BWC, 8'h80);
    lock <= 1'b1;
    trk <= 1'b1;
    repeat (5) @(posedge clk);
    rc(`PLLC_OFF_BWC, 8'hE0);
    `CHK("tracking", 1'b1, cfg.tracking_mode);
    wr(`PLLC_OFF_BWC, 8'h00);
    rc(`PLLC_OFF_BWC, 8'h20);
    wr(`PLLC_OFF_CTRL, 8'hA0);
    rc(`PLLC_OFF_CTRL, 8'h20);
    lock <= 1'b0;
    repeat (6) @(posedge clk);
    rc(`PLLC_OFF_CTRL, 8'h20);
    wr(`PLLC_OFF_BWC, 8'h80);
    repeat (6) @(posedge clk);
    // entering automatic mode may or may not flag; clear it before counting
    apb(1'b0, `PLLC_OFF_CTRL, 8'h00);
    wr(`PLLC_OFF_CTRL, 8'hA0);
    lock <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("irq", 1'b1, irq);
    rc(`PLLC_OFF_BWC, 8'hE0);
    rc(`PLLC_OFF_CTRL, 8'hE0);
    rc(`PLLC_OFF_CTRL, 8'hA0);
    `CHK("irq", 1'b0, irq);
    wr(`PLLC_OFF_CTRL, 8'h20);
    lock <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("irq", 1'b0, irq);
    rc(`PLLC_OFF_CTRL, 8'h60);
    wr(`PLLC_OFF_CTRL, 8'hA0);
    wr(`PLLC_OFF_BWC, 8'h00);
    rc(`PLLC_OFF_CTRL, 8'h20);
    wr(`PLLC_OFF_CTRL, 8'h20);
    wt <= 1'b1;
    repeat (3) @(posedge clk);
    rc(`PLLC_OFF_CTRL, 8'h20);
    complete_run();
  end
endmodule : pllc_top_tb
